// File: src/btsb_addr_gen.sv
// Effective data address generator for bit-oriented instructions.
// Assumes the index register value is supplied by the core when indexed mode is used.
`timescale 1ns/1ns
module btsb_addr_gen
  import btsb_pkg::*;
(
  // Instruction fields
  input wire logic [7:0] file_addr,
  input wire logic access_flag,
  // Core state
  input wire logic [3:0] bank_select_reg,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  // Result
  output btsb_addr_s result
);
  // Mode chosen once, address formed from that mode
  always_comb begin
    result.ilo = 1'b0;
    if (access_flag) begin
      result.addr = {bank_select_reg, file_addr};
    end else if (ext_set_en && (file_addr <= BTSB_ILO_LIMIT)) begin
      result.ilo = 1'b1;
      result.addr = index_base + {4'h0, file_addr};
    end else if (file_addr < BTSB_ACCESS_SPLIT) begin
      result.addr = {4'h0, file_addr};
    end else begin
      result.addr = {BTSB_ACCESS_HIGH_BANK, file_addr};
    end
  end
endmodule

// File: src/btsb_exec.sv
// Executor for skip-if-bit-set, bit invert and branch on overflow.
// Assumes the fetch path presents instr_word with instr_valid at each cycle's Q1,
// next_two_word flags a two-word follower, and read data returns by Q3.
`timescale 1ns/1ns
module btsb_exec
  import btsb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Instruction fetch
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic next_two_word,
  // Core state
  input wire logic [3:0] bank_select_reg,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  input wire logic overflow_flag,
  // Data memory
  input wire logic [7:0] mem_rdata,
  output btsb_mem_s mem,
  // Program counter and status
  output logic [20:0] pc,
  output logic pc_write,
  output logic dummy_cycle,
  output logic flags_write,
  output btsb_q_e q_phase
);
  // Run state: executing fetched words or burning inserted dummy cycles
  typedef enum logic [1:0] {BTSB_ST_RUN, BTSB_ST_DUMMY} btsb_st_e;

  // Sequencing state
  btsb_st_e st;
  btsb_st_e next_st;
  logic [1:0] dummy_left;
  logic [1:0] next_dummy_left;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic [20:0] next_pc;
  logic next_pc_write;
  logic next_dummy_cycle;
  // Phase, memory and status next values
  btsb_q_e next_q;
  btsb_mem_s next_mem;
  logic next_flags_write;
  // Shared decode results
  btsb_addr_s ea;
  logic [7:0] bit_mask;
  logic running;
  logic bit_op;
  logic skip_hit;
  logic branch_hit;
  logic last_dummy;
  logic [20:0] branch_target;

  // Opcode match helpers, used in several phases
  function automatic logic is_invert(input logic [15:0] w);
    return w[15:12] == BTSB_OP_INVERT;
  endfunction
  function automatic logic is_skip(input logic [15:0] w);
    return w[15:12] == BTSB_OP_SKIPSET;
  endfunction
  function automatic logic is_bov(input logic [15:0] w);
    return w[15:8] == BTSB_OP_BRANCH_OV;
  endfunction
  // Bit-oriented words request their target byte in Q2 and read it under the Q3 strobe
  function automatic logic is_bit_op(input logic [15:0] w);
    return is_invert(w) || is_skip(w);
  endfunction

  btsb_addr_gen u_addr (
    .file_addr(ir[7:0]),
    .access_flag(ir[8]),
    .bank_select_reg(bank_select_reg),
    .ext_set_en(ext_set_en),
    .index_base(index_base),
    .result(ea)
  );

  assign bit_mask = 8'h01 << ir[11:9];

  // Decisions shared by the sequencing and memory groups
  assign running = (st == BTSB_ST_RUN);
  assign bit_op = running && is_bit_op(ir);
  // skip only when tested bit is 1
  assign skip_hit = running && is_skip(ir) && ((mem_rdata & bit_mask) != 8'h00);
  assign branch_hit = running && is_bov(ir) && overflow_flag;
  assign branch_target = pc + {{12{ir[7]}}, ir[7:0], 1'b0};
  // Final quarter of the last dummy cycle hands control back
  assign last_dummy = !running && (dummy_left == 2'd1);

  // Quarter-phase ring, one quarter per clock; it never stalls
  always_comb begin
    next_q = BTSB_Q1;
    case (q_phase)
      BTSB_Q1: begin
        next_q = BTSB_Q2;
      end
      BTSB_Q2: begin
        next_q = BTSB_Q3;
      end
      BTSB_Q3: begin
        next_q = BTSB_Q4;
      end
      BTSB_Q4: begin
        next_q = BTSB_Q1;
      end
      default: begin
        next_q = BTSB_Q1;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_phase <= BTSB_Q1;
    end else begin
      q_phase <= next_q;
    end
  end

  // Instruction sequencing, program counter and dummy cycles
  always_comb begin
    next_st = st;
    next_dummy_left = dummy_left;
    next_ir = ir;
    next_pc = pc;
    next_pc_write = 1'b0;
    next_dummy_cycle = dummy_cycle;
    case (q_phase)
      BTSB_Q1: begin
        if (running) begin
          // Decode: a missing word executes as a no-op
          next_ir = instr_valid ? instr_word : 16'h0000;
          next_dummy_cycle = 1'b0;
          if (instr_valid) begin
            // PC points past this word while it executes
            next_pc = pc + BTSB_PC_STEP;
          end
        end
      end
      BTSB_Q4: begin
        if (!running) begin
          next_dummy_left = dummy_left - 2'd1;
          if (last_dummy) begin
            // Flag drops here so it never spills into the next fetch
            next_st = BTSB_ST_RUN;
            next_dummy_cycle = 1'b0;
          end
        end else if (skip_hit) begin
          next_st = BTSB_ST_DUMMY;
          next_dummy_cycle = 1'b1;
          next_dummy_left = next_two_word ? 2'd2 : 2'd1;
          next_pc = pc + (next_two_word ? (BTSB_PC_STEP << 1) : BTSB_PC_STEP);
        end else if (branch_hit) begin
          next_pc = branch_target;
          next_pc_write = 1'b1;
          next_st = BTSB_ST_DUMMY;
          next_dummy_cycle = 1'b1;
          next_dummy_left = 2'd1;
        end
      end
      default: begin
        next_st = st;
      end
    endcase
  end

  // Sequencing registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= BTSB_ST_RUN;
      dummy_left <= 2'd0;
      ir <= 16'h0000;
      pc <= BTSB_PC_RESET;
      pc_write <= 1'b0;
      dummy_cycle <= 1'b0;
    end else begin
      st <= next_st;
      dummy_left <= next_dummy_left;
      ir <= next_ir;
      pc <= next_pc;
      pc_write <= next_pc_write;
      dummy_cycle <= next_dummy_cycle;
    end
  end

  // Data memory request: read strobe in Q3, write strobe in Q1 of the next cycle
  always_comb begin
    next_mem = mem;
    case (q_phase)
      BTSB_Q1: begin
        // Write strobe lasts one quarter only
        next_mem.wr = 1'b0;
      end
      BTSB_Q2: begin
        // Read register f for bit instructions
        next_mem.rd = bit_op;
        next_mem.addr = ea.addr;
      end
      BTSB_Q3: begin
        next_mem.rd = 1'b0;
        next_mem.wdata = mem_rdata ^ bit_mask;
      end
      BTSB_Q4: begin
        next_mem.wr = running && is_invert(ir);
      end
      default: begin
        next_mem.wr = 1'b0;
      end
    endcase
  end

  // Memory request register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem <= '0;
    end else begin
      mem <= next_mem;
    end
  end

  // Status flags: none of these instructions touches them
  always_comb begin
    next_flags_write = 1'b0;
  end

  // Status register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_write <= 1'b0;
    end else begin
      flags_write <= next_flags_write;
    end
  end
endmodule

// File: src/btsb_pkg.sv
// Constants and carrier types for the skip / bit-invert / overflow-branch executor.
// Assumes a core that fetches 16-bit words and supplies status, bank and mode inputs.
package btsb_pkg;
  localparam logic [3:0] BTSB_OP_INVERT = 4'h7;
  localparam logic [3:0] BTSB_OP_SKIPSET = 4'ha;
  localparam logic [7:0] BTSB_OP_BRANCH_OV = 8'he4;
  localparam logic [7:0] BTSB_ILO_LIMIT = 8'h5f;
  localparam logic [7:0] BTSB_ACCESS_SPLIT = 8'h60; // Access bank low/high split
  localparam logic [3:0] BTSB_ACCESS_HIGH_BANK = 4'hf;
  localparam logic [20:0] BTSB_PC_RESET = 21'h00_0000;
  localparam logic [20:0] BTSB_PC_STEP = 21'h00_0002;
  localparam int BTSB_CLK_NS = 100;

  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {BTSB_Q1, BTSB_Q2, BTSB_Q3, BTSB_Q4} btsb_q_e;

  // Data memory request towards the core data path
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } btsb_mem_s;

  // Decoded addressing of a bit-oriented instruction
  typedef struct packed {
    logic [11:0] addr;
    logic ilo;
  } btsb_addr_s;
endpackage

// File: tb/bit_toggle_skip_overflow_branch_exec_tb.sv
// Bench for the executor with a data memory partner.
// Assumes the fetch path is played by the main process.
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module bit_toggle_skip_overflow_branch_exec_tb import btsb_pkg::*;;
  logic clk = 0, sys_rst = 1, instr_valid = 0, next_two_word = 0, ext_set_en = 0;
  logic overflow_flag = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_reg = 4'h0;
  logic [11:0] index_base = 12'h000, ea, wa = 12'h000;
  logic [7:0] mem_rdata, f, d, n, wv = 8'h00;
  logic [2:0] b;
  logic [20:0] pc, pc_exp = 21'h00_0000, notes[$], note;
  logic pc_write, dummy_cycle, flags_write, a;
  btsb_mem_s mem;
  btsb_q_e q_phase;
  int err_count = 0, samples_checked = 0, nd, dc;
  btsb_exec DUT (.clk, .sys_rst, .instr_word, .instr_valid, .next_two_word, .bank_select_reg,
    .ext_set_en, .index_base, .overflow_flag, .mem_rdata, .mem, .pc, .pc_write, .dummy_cycle,
    .flags_write, .q_phase);
  btsb_mem_model mdl (.clk, .sys_rst, .mem, .mem_rdata);
  initial forever #50 clk = ~clk;
  // Watchdog, run needs at most about 39 us
  initial begin
    #200_000;
    err_count++;
    results();
  end
  // Watcher takes the oldest note on every write or pc load
  always @(posedge clk) begin
    #1;
    // Pop once per result so a mismatch report cannot eat a second note
    if (mem.wr === 1'b1) begin
      note = notes.pop_front();
      `CHK({1'b0, mem.addr, mem.wdata}, note)
    end
    if (pc_write === 1'b1) begin
      note = notes.pop_front();
      `CHK(pc, note)
    end
  end
  // Fixed rotation of all three instructions with random operands, aligned to Q1
  initial begin
    void'($urandom(32'h0b4c));
    repeat (8) @(negedge clk);
    sys_rst = 0;
    for (int i = 0; i < 48; i++) begin
      {n, f, b, a, bank_select_reg, next_two_word} = $urandom;
      {ext_set_en, index_base, overflow_flag} = $urandom;
      if (a) ea = {bank_select_reg, f};
      else if (ext_set_en && f <= BTSB_ILO_LIMIT) ea = index_base + {4'h0, f};
      else ea = {(f < BTSB_ACCESS_SPLIT) ? 4'h0 : BTSB_ACCESS_HIGH_BANK, f};
      // The previous invert lands only at the coming edge, so use its expected byte
      d = (i % 3 == 1 && ea == wa) ? wv : mdl.ram[ea];
      nd = 0;
      case (i % 3)
        0: begin
          instr_word = {BTSB_OP_INVERT, b, a, f};
          wa = ea;
          wv = d ^ (8'h01 << b);
          notes.push_back({1'b0, wa, wv});
        end
        1: begin
          instr_word = {BTSB_OP_SKIPSET, b, a, f};
          nd = d[b] ? 1 + next_two_word : 0;
        end
        default: begin
          instr_word = {BTSB_OP_BRANCH_OV, n};
          nd = overflow_flag;
          if (nd) notes.push_back(pc_exp + 2 + {{12{n[7]}}, n, 1'b0});
        end
      endcase
      pc_exp = (nd && i % 3 == 2) ? notes[$] : pc_exp + 2 + 2 * nd;
      instr_valid = 1;
      @(negedge clk) instr_valid = 0;
      dc = 0;
      repeat (3 + 4 * nd) @(negedge clk) dc += (dummy_cycle === 1'b1);
      `CHK(dc, 4 * nd)
      `CHK(pc, pc_exp)
      $display("test %0d done", i);
    end
    `CHK(notes.size(), 0)
    results();
  end
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
endmodule
bind btsb_exec btsb_exec_sva chk (.clk, .sys_rst, .mem, .pc_write, .dummy_cycle,
  .flags_write, .q_phase);

// File: tb/btsb_exec_sva.sv
// Port checker for the executor.
// Assumes binding from the bench top.
`timescale 1ns/1ns
module btsb_exec_sva
  import btsb_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire btsb_mem_s mem,
  input wire logic pc_write,
  input wire logic dummy_cycle,
  input wire logic flags_write,
  input wire btsb_q_e q_phase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Phase ring and strobe shapes
  a_flags_never: assert property (!flags_write) else $error("flag write");
  a_phase_after_q1: assert property (q_phase == BTSB_Q1 |=> q_phase == BTSB_Q2)
    else $error("phase step");
  a_phase_after_q4: assert property (q_phase == BTSB_Q4 |=> q_phase == BTSB_Q1)
    else $error("phase wrap");
  a_pcw_one_clock: assert property (pc_write |=> !pc_write) else $error("pc pulse");
  a_pcw_with_dummy: assert property (pc_write |-> dummy_cycle && q_phase == BTSB_Q1)
    else $error("taken branch idle");
  a_dummy_cycle_len: assert property ($rose(dummy_cycle) |-> dummy_cycle [*4])
    else $error("dummy length");
  a_dummy_ends_q1: assert property ($fell(dummy_cycle) |-> q_phase == BTSB_Q1)
    else $error("dummy overrun");
  a_wr_one_clock: assert property (mem.wr |=> !mem.wr) else $error("write pulse");
  a_wr_at_q1: assert property (mem.wr |-> q_phase == BTSB_Q1 && !pc_write)
    else $error("write phase");
  c_taken: cover property (pc_write);
  c_write: cover property (mem.wr);
  c_dummy: cover property ($rose(dummy_cycle));
  c_two_dummies: cover property (dummy_cycle [*8]);
endmodule

// File: tb/btsb_mem_model.sv
// Data memory partner of the executor.
// Assumes read data is wanted for one clock past the read strobe.
`timescale 1ns/1ns
module btsb_mem_model
  import btsb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Memory port
  input wire btsb_mem_s mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:4095];
  logic hold = 1'b0;
  logic [7:0] last = 8'h00;
  // Preset bytes, distinct within each run of 256 addresses
  initial for (int i = 0; i < 4096; i++) ram[i] = 8'(i * 7 + 3);
  always @(posedge clk) begin
    if (mem.wr) ram[mem.addr] <= mem.wdata;
    hold <= mem.rd && !sys_rst;
    if (mem.rd || hold) last <= ram[mem.addr];
  end
  // Released bus shows the inverse so stale data cannot pass
  assign mem_rdata = (mem.rd || hold) ? ram[mem.addr] : ~last;
endmodule
